// File: wuac_channel.sv
`timescale 1ns/1ps
`default_nettype none

module wuac_channel (
  input  wire logic                  i_clk,
  input  wire logic                  i_reset_n,
  input  wire wuac_pkg::wuac_cfg_s   i_cfg,
  input  wire logic [7:0]            i_reference,
  input  wire wuac_pkg::wuac_meas_s  i_meas,
  output var  wuac_pkg::wuac_chan_out_s o_chan
);

  // ----------------------------------------------------------------
  // compare against reference
  // ----------------------------------------------------------------
  logic [7:0]        cmp_ref;
  logic signed [9:0] diff;
  logic [8:0]        magnitude;
  logic              exceed;
  logic signed [9:0] delta;
  logic signed [9:0] step;
  logic signed [9:0] next_avg_wide;
  logic              fold_in;

  always_comb begin
    cmp_ref = i_cfg.ref_select ? o_chan.average : i_reference;
    diff = $signed({2'b00, i_meas.data}) - $signed({2'b00, cmp_ref});
    magnitude = diff[9] ? 9'(-diff) : diff[8:0];
    exceed = magnitude > {5'h00, i_cfg.threshold};
  end

  // ----------------------------------------------------------------
  // running average
  // ----------------------------------------------------------------
  always_comb begin
    delta = $signed({2'b00, i_meas.data}) - $signed({2'b00, o_chan.average});
    step = delta >>> (wuac_pkg::WEIGHT_SHIFT0 + 32'(i_cfg.avg_weight));
    next_avg_wide = $signed({2'b00, o_chan.average}) + step;
    fold_in = !exceed || i_cfg.avg_policy;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_chan <= '{average: wuac_pkg::RST_AVG, result: wuac_pkg::RST_RES, wake: 1'b0};
    end else begin
      o_chan.wake <= i_meas.valid && exceed;
      if (i_meas.valid) begin
        o_chan.result <= i_meas.data;
        if (fold_in) begin
          o_chan.average <= next_avg_wide[7:0];
        end
      end
    end
  end

endmodule : wuac_channel

`default_nettype wire

// File: wuac_pkg.sv
package wuac_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W        = 12;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned REG_W         = 8;

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0]  IDX_AMP_CFG   = 8'h33;
  localparam logic [7:0]  IDX_AMP_REF   = 8'h34;
  localparam logic [7:0]  IDX_AMP_AVG   = 8'h35;
  localparam logic [7:0]  IDX_AMP_RES   = 8'h36;
  localparam logic [7:0]  IDX_PH_CFG    = 8'h37;
  localparam logic [7:0]  IDX_PH_REF    = 8'h38;
  localparam logic [7:0]  IDX_PH_AVG    = 8'h39;
  localparam logic [7:0]  IDX_PH_RES    = 8'h3a;
  localparam logic [7:0]  IDX_WAKE_CTRL = 8'h40;
  localparam logic [7:0]  IDX_IRQ_STAT  = 8'h41;
  localparam logic [7:0]  IDX_IRQ_MASK  = 8'h42;

  // ----------------------------------------------------------------
  // configuration field positions
  // ----------------------------------------------------------------
  localparam int unsigned THR_MSB       = 7;
  localparam int unsigned THR_LSB       = 4;
  localparam int unsigned POLICY_BIT    = 3;
  localparam int unsigned WEIGHT_MSB    = 2;
  localparam int unsigned WEIGHT_LSB    = 1;
  localparam int unsigned REFSEL_BIT    = 0;
  localparam int unsigned WEIGHT_SHIFT0 = 2;

  // ----------------------------------------------------------------
  // wake control and interrupt bit positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_AMP_EN   = 2;
  localparam int unsigned CTRL_PH_EN    = 1;
  localparam int unsigned ST_AMP_WAKE   = 0;
  localparam int unsigned ST_PH_WAKE    = 1;
  localparam int unsigned ST_AMP_TMO    = 2;
  localparam int unsigned ST_PH_TMO     = 3;
  localparam int unsigned ST_W          = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_CFG       = 8'h00;
  localparam logic [7:0]  RST_REF       = 8'h00;
  localparam logic [7:0]  RST_AVG       = 8'h00;
  localparam logic [7:0]  RST_RES       = 8'h00;
  localparam logic [7:0]  RST_CTRL      = 8'h00;
  localparam logic [3:0]  RST_STAT      = 4'h0;
  localparam logic [3:0]  RST_MASK      = 4'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ       = 125;
  localparam int unsigned MEAS_TMO_NS   = 2000;
  localparam int unsigned MEAS_TMO_CYC  = (MEAS_TMO_NS * CLK_MHZ) / 1000;
  localparam int unsigned TMO_W         = 9;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] threshold;
    logic       avg_policy;
    logic [1:0] avg_weight;
    logic       ref_select;
  } wuac_cfg_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } wuac_meas_s;

  typedef struct packed {
    logic [7:0] average;
    logic [7:0] result;
    logic       wake;
  } wuac_chan_out_s;

  typedef enum logic [2:0] {
    MEAS_IDLE = 3'b001,
    MEAS_REQ  = 3'b010,
    MEAS_WAIT = 3'b100
  } wuac_state_e;

endpackage : wuac_pkg

// File: wuac_top.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - amplitude threshold is config bits 7..4; difference above it raises wake
// - amplitude policy 0 keeps an interrupting result out of the average, 1 folds it
// - two-bit weight code 00/01/10/11 divides the average step by 4/8/16/32
// - amplitude reference select 0 compares against the written amplitude reference
// - phase threshold is config bits 7..4; difference above it raises wake
// - phase policy 1 folds an interrupting result into the average, 0 excludes
// - phase reference select 0 uses written reference, 1 uses running average
// - amplitude reference is a read-write 8-bit register at index 34h, reset zero
// - amplitude running average readable at index 35h
// - latest amplitude result readable at index 36h
// - phase reference is a read-write 8-bit register at index 38h, reset zero
// - phase running average readable at index 39h
// - latest phase result readable at index 3Ah
// - amplitude enable makes each timeout arriving while the amplitude channel is idle run an amplitude measurement and check
// - phase enable makes each timeout arriving while the phase channel is idle run a phase measurement and check
module wuac_top (
  input  wire logic                        i_clk,
  input  wire logic                        i_reset_n,
  input  wire logic                        i_psel,
  input  wire logic                        i_penable,
  input  wire logic                        i_pwrite,
  input  wire logic [wuac_pkg::ADDR_W-1:0] i_paddr,
  input  wire logic [wuac_pkg::DATA_W-1:0] i_pwdata,
  input  wire logic [3:0]                  i_pstrb,
  output var  logic [wuac_pkg::DATA_W-1:0] o_prdata,
  output var  logic                        o_pready,
  output var  logic                        o_pslverr,
  input  wire logic                        i_wake_timeout,
  output var  logic                        o_amp_meas_req,
  input  wire wuac_pkg::wuac_meas_s        i_amp_meas,
  output var  logic                        o_phase_meas_req,
  input  wire wuac_pkg::wuac_meas_s        i_phase_meas,
  output var  logic                        o_irq
);

  // ----------------------------------------------------------------
  // address decode helper
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [wuac_pkg::ADDR_W-1:0] addr,
                                    input logic [7:0] idx);
    addr_hit = addr == {2'b00, idx, 2'b00};
  endfunction : addr_hit

  function automatic logic addr_mapped(input logic [wuac_pkg::ADDR_W-1:0] addr);
    addr_mapped = addr_hit(addr, wuac_pkg::IDX_AMP_CFG)
               || addr_hit(addr, wuac_pkg::IDX_AMP_REF)
               || addr_hit(addr, wuac_pkg::IDX_AMP_AVG)
               || addr_hit(addr, wuac_pkg::IDX_AMP_RES)
               || addr_hit(addr, wuac_pkg::IDX_PH_CFG)
               || addr_hit(addr, wuac_pkg::IDX_PH_REF)
               || addr_hit(addr, wuac_pkg::IDX_PH_AVG)
               || addr_hit(addr, wuac_pkg::IDX_PH_RES)
               || addr_hit(addr, wuac_pkg::IDX_WAKE_CTRL)
               || addr_hit(addr, wuac_pkg::IDX_IRQ_STAT)
               || addr_hit(addr, wuac_pkg::IDX_IRQ_MASK);
  endfunction : addr_mapped

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic                 setup_phase;
  logic                 access_phase;
  logic                 wr_en;
  logic                 lane0_en;
  logic [7:0]           wr_byte;
  logic [7:0]           amp_cfg;
  logic [7:0]           amp_ref;
  logic [7:0]           ph_cfg;
  logic [7:0]           ph_ref;
  logic [7:0]           wake_ctrl;
  logic [wuac_pkg::ST_W-1:0] irq_stat;
  logic [wuac_pkg::ST_W-1:0] irq_mask;
  logic [wuac_pkg::ST_W-1:0] stat_set;
  logic [wuac_pkg::ST_W-1:0] stat_clr;
  logic [7:0]           next_rdata;
  logic                 rd_miss;
  wuac_pkg::wuac_cfg_s  chan_cfg [2];
  logic [7:0]           chan_ref [2];
  wuac_pkg::wuac_meas_s chan_meas_in [2];
  wuac_pkg::wuac_meas_s chan_meas [2];
  wuac_pkg::wuac_chan_out_s chan_out [2];
  logic [1:0]           chan_en;
  logic [1:0]           chan_req;
  logic [1:0]           chan_tmo;

  // ----------------------------------------------------------------
  // apb handshake
  // ----------------------------------------------------------------
  assign setup_phase  = i_psel && !i_penable;
  assign access_phase = i_psel && i_penable;
  assign wr_en        = access_phase && o_pready && i_pwrite && !o_pslverr;
  assign lane0_en     = i_pstrb[0];
  assign wr_byte      = i_pwdata[7:0];

  // read data is captured in setup, so the access phase always completes at once
  always_comb begin
    o_pready  = 1'b1;
    o_pslverr = access_phase && !addr_mapped(i_paddr);
  end

  // ----------------------------------------------------------------
  // configuration and reference registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      amp_cfg <= wuac_pkg::RST_CFG;
      ph_cfg  <= wuac_pkg::RST_CFG;
    end else if (wr_en && lane0_en) begin
      if (addr_hit(i_paddr, wuac_pkg::IDX_AMP_CFG)) begin
        amp_cfg <= wr_byte;
      end else if (addr_hit(i_paddr, wuac_pkg::IDX_PH_CFG)) begin
        ph_cfg <= wr_byte;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      amp_ref <= wuac_pkg::RST_REF;
      ph_ref  <= wuac_pkg::RST_REF;
    end else if (wr_en && lane0_en) begin
      if (addr_hit(i_paddr, wuac_pkg::IDX_AMP_REF)) begin
        amp_ref <= wr_byte;
      end else if (addr_hit(i_paddr, wuac_pkg::IDX_PH_REF)) begin
        ph_ref <= wr_byte;
      end
    end
  end

  // ----------------------------------------------------------------
  // wake control register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wake_ctrl <= wuac_pkg::RST_CTRL;
    end else if (wr_en && lane0_en && addr_hit(i_paddr, wuac_pkg::IDX_WAKE_CTRL)) begin
      wake_ctrl <= wr_byte & ((8'h01 << wuac_pkg::CTRL_AMP_EN)
                            | (8'h01 << wuac_pkg::CTRL_PH_EN));
    end
  end

  // ----------------------------------------------------------------
  // interrupt status, mask and output
  // ----------------------------------------------------------------
  always_comb begin
    stat_set = '0;
    stat_set[wuac_pkg::ST_AMP_WAKE] = chan_out[0].wake;
    stat_set[wuac_pkg::ST_PH_WAKE]  = chan_out[1].wake;
    stat_set[wuac_pkg::ST_AMP_TMO]  = chan_tmo[0];
    stat_set[wuac_pkg::ST_PH_TMO]   = chan_tmo[1];
    stat_clr = '0;
    if (wr_en && lane0_en && addr_hit(i_paddr, wuac_pkg::IDX_IRQ_STAT)) begin
      stat_clr = wr_byte[wuac_pkg::ST_W-1:0];
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_stat <= wuac_pkg::RST_STAT;
    end else begin
      irq_stat <= (irq_stat & ~stat_clr) | stat_set;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_mask <= wuac_pkg::RST_MASK;
    end else if (wr_en && lane0_en && addr_hit(i_paddr, wuac_pkg::IDX_IRQ_MASK)) begin
      irq_mask <= wr_byte[wuac_pkg::ST_W-1:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(((irq_stat & ~stat_clr) | stat_set) & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    rd_miss    = 1'b0;
    if (addr_hit(i_paddr, wuac_pkg::IDX_AMP_CFG)) begin
      next_rdata = amp_cfg;
    end else if (addr_hit(i_paddr, wuac_pkg::IDX_AMP_REF)) begin
      next_rdata = amp_ref;
    end else if (addr_hit(i_paddr, wuac_pkg::IDX_AMP_AVG)) begin
      next_rdata = chan_out[0].average;
    end else if (addr_hit(i_paddr, wuac_pkg::IDX_AMP_RES)) begin
      next_rdata = chan_out[0].result;
    end else if (addr_hit(i_paddr, wuac_pkg::IDX_PH_CFG)) begin
      next_rdata = ph_cfg;
    end else if (addr_hit(i_paddr, wuac_pkg::IDX_PH_REF)) begin
      next_rdata = ph_ref;
    end else if (addr_hit(i_paddr, wuac_pkg::IDX_PH_AVG)) begin
      next_rdata = chan_out[1].average;
    end else if (addr_hit(i_paddr, wuac_pkg::IDX_PH_RES)) begin
      next_rdata = chan_out[1].result;
    end else if (addr_hit(i_paddr, wuac_pkg::IDX_WAKE_CTRL)) begin
      next_rdata = wake_ctrl;
    end else if (addr_hit(i_paddr, wuac_pkg::IDX_IRQ_STAT)) begin
      next_rdata = {4'h0, irq_stat};
    end else if (addr_hit(i_paddr, wuac_pkg::IDX_IRQ_MASK)) begin
      next_rdata = {4'h0, irq_mask};
    end else begin
      rd_miss = 1'b1;
    end
  end

  // captured in setup; a result landing during access shows on the next read
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_prdata <= '0;
    end else if (setup_phase && !i_pwrite) begin
      o_prdata <= rd_miss ? '0 : {24'h000000, next_rdata};
    end
  end

  // ----------------------------------------------------------------
  // channel wiring
  // ----------------------------------------------------------------
  always_comb begin
    chan_cfg[0]     = wuac_pkg::wuac_cfg_s'(amp_cfg);
    chan_cfg[1]     = wuac_pkg::wuac_cfg_s'(ph_cfg);
    chan_ref[0]     = amp_ref;
    chan_ref[1]     = ph_ref;
    chan_meas_in[0] = i_amp_meas;
    chan_meas_in[1] = i_phase_meas;
    chan_en[0]      = wake_ctrl[wuac_pkg::CTRL_AMP_EN];
    chan_en[1]      = wake_ctrl[wuac_pkg::CTRL_PH_EN];
    o_amp_meas_req   = chan_req[0];
    o_phase_meas_req = chan_req[1];
  end

  // ----------------------------------------------------------------
  // per channel measurement sequencing
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_chan
    wuac_pkg::wuac_state_e state;
    wuac_pkg::wuac_state_e next_state;
    logic [wuac_pkg::TMO_W-1:0] wait_cnt;
    logic                       wait_done;

    assign wait_done = wait_cnt == wuac_pkg::TMO_W'(wuac_pkg::MEAS_TMO_CYC - 1);

    always_comb begin
      next_state = state;
      case (state)
        wuac_pkg::MEAS_IDLE: begin
          if (i_wake_timeout && chan_en[g]) begin
            next_state = wuac_pkg::MEAS_REQ;
          end
        end
        wuac_pkg::MEAS_REQ: begin
          next_state = wuac_pkg::MEAS_WAIT;
        end
        wuac_pkg::MEAS_WAIT: begin
          if (chan_meas_in[g].valid || wait_done) begin
            next_state = wuac_pkg::MEAS_IDLE;
          end
        end
        default: begin
          next_state = wuac_pkg::MEAS_IDLE;
        end
      endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
        state <= wuac_pkg::MEAS_IDLE;
      end else begin
        state <= next_state;
      end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
        wait_cnt <= '0;
      end else if (state == wuac_pkg::MEAS_WAIT) begin
        wait_cnt <= wait_cnt + 1'b1;
      end else begin
        wait_cnt <= '0;
      end
    end

    always_comb begin
      chan_req[g]        = state == wuac_pkg::MEAS_REQ;
      chan_tmo[g]        = state == wuac_pkg::MEAS_WAIT && wait_done
                           && !chan_meas_in[g].valid;
      chan_meas[g].valid = state == wuac_pkg::MEAS_WAIT && chan_meas_in[g].valid;
      chan_meas[g].data  = chan_meas_in[g].data;
    end

    wuac_channel u_channel (
      .i_clk       (i_clk),
      .i_reset_n   (i_reset_n),
      .i_cfg       (chan_cfg[g]),
      .i_reference (chan_ref[g]),
      .i_meas      (chan_meas[g]),
      .o_chan      (chan_out[g])
    );
  end

endmodule : wuac_top

`default_nettype wire

// File: wuac_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module wuac_top_properties (
  input wire logic                 i_clk,
  input wire logic                 i_reset_n,
  input wire logic                 i_psel,
  input wire logic                 i_penable,
  input wire logic                 i_pwrite,
  input wire logic [11:0]          i_paddr,
  input wire logic [31:0]          i_pwdata,
  input wire logic [3:0]           i_pstrb,
  input wire logic [31:0]          o_prdata,
  input wire logic                 o_pready,
  input wire logic                 o_pslverr,
  input wire logic                 i_wake_timeout,
  input wire logic                 o_amp_meas_req,
  input wire wuac_pkg::wuac_meas_s i_amp_meas,
  input wire logic                 o_phase_meas_req,
  input wire logic                 o_irq
);
  // ------------------------------
  // shadow state
  // ------------------------------
  localparam logic [11:0] A_AREF = {2'b00, wuac_pkg::IDX_AMP_REF, 2'b00};
  localparam logic [11:0] A_PREF = {2'b00, wuac_pkg::IDX_PH_REF, 2'b00};
  localparam logic [11:0] A_ARES = {2'b00, wuac_pkg::IDX_AMP_RES, 2'b00};
  logic       wr_en;
  logic       rd_en;
  logic       amp_wait;
  logic [7:0] aref_sh;
  logic [7:0] pref_sh;
  logic [7:0] ares_sh;
  assign wr_en = i_psel && i_penable && i_pwrite && i_pstrb[0];
  assign rd_en = i_psel && i_penable && !i_pwrite;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      aref_sh <= 8'h00;
      pref_sh <= 8'h00;
    end else if (wr_en && i_paddr == A_AREF) begin
      aref_sh <= i_pwdata[7:0];
    end else if (wr_en && i_paddr == A_PREF) begin
      pref_sh <= i_pwdata[7:0];
    end
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      amp_wait <= 1'b0;
      ares_sh  <= 8'h00;
    end else if (o_amp_meas_req) begin
      amp_wait <= 1'b1;
    end else if (amp_wait && i_amp_meas.valid) begin
      amp_wait <= 1'b0;
      ares_sh  <= i_amp_meas.data;
    end
  end
  // ------------------------------
  // properties
  // ------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  pready_high_a: assert property (o_pready)
    else $error("pready low");
  hole_error_a: assert property (rd_en && i_paddr == 12'h0ec |-> o_pslverr && o_prdata == 0)
    else $error("unmapped read not refused");
  error_in_access_a: assert property (o_pslverr |-> i_psel && i_penable)
    else $error("pslverr outside access");
  upper_zero_a: assert property (rd_en |-> o_prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  amp_req_cause_a: assert property (o_amp_meas_req |-> $past(i_wake_timeout))
    else $error("amplitude request without timeout");
  ph_req_cause_a: assert property (o_phase_meas_req |-> $past(i_wake_timeout))
    else $error("phase request without timeout");
  amp_req_pulse_a: assert property (o_amp_meas_req |=> !o_amp_meas_req)
    else $error("amplitude request longer than one cycle");
  amp_ref_read_a: assert property (rd_en && i_paddr == A_AREF |-> o_prdata[7:0] == aref_sh)
    else $error("amplitude reference readback wrong");
  ph_ref_read_a: assert property (rd_en && i_paddr == A_PREF |-> o_prdata[7:0] == pref_sh)
    else $error("phase reference readback wrong");
  amp_res_read_a: assert property (rd_en && i_paddr == A_ARES |-> o_prdata[7:0] == ares_sh)
    else $error("amplitude result view wrong");
  irq_rise_c: cover property ($rose(o_irq));
  slverr_c: cover property (o_pslverr);
  ph_req_c: cover property (o_phase_meas_req);
endmodule : wuac_top_properties

bind wuac_top wuac_top_properties i_props (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_wake_timeout(i_wake_timeout), .o_amp_meas_req(o_amp_meas_req),
  .i_amp_meas(i_amp_meas), .o_phase_meas_req(o_phase_meas_req), .o_irq(o_irq)
);
`default_nettype wire

// File: wuac_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module wuac_top_tb;
  // ------------------------------
  // stimulus and dut
  // ------------------------------
  logic                 i_clk = 1'b0;
  logic                 i_reset_n = 1'b0;
  logic                 i_psel = 1'b0;
  logic                 i_penable = 1'b0;
  logic                 i_pwrite = 1'b0;
  logic [11:0]          i_paddr = 12'h000;
  logic [31:0]          i_pwdata = 32'h0;
  logic [3:0]           i_pstrb = 4'h0;
  logic                 i_wake_timeout = 1'b0;
  wuac_pkg::wuac_meas_s i_amp_meas = 9'h000;
  wuac_pkg::wuac_meas_s i_phase_meas = 9'h000;
  logic [31:0]          o_prdata;
  logic                 o_pready, o_pslverr, o_amp_meas_req, o_phase_meas_req, o_irq;
  int                   n_errors = 0;
  int                   checks_done = 0;
  logic [7:0]           cfg[2], refv[2], avg[2];
  logic [3:0]           mask_v;
  logic [31:0]          rdv;
  logic                 err;
  always #4 i_clk = ~i_clk;
  wuac_top i_wuac_top (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_wake_timeout(i_wake_timeout), .o_amp_meas_req(o_amp_meas_req),
    .i_amp_meas(i_amp_meas), .o_phase_meas_req(o_phase_meas_req),
    .i_phase_meas(i_phase_meas), .o_irq(o_irq)
  );
  // ------------------------------
  // bus and check tasks
  // ------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                     input logic [3:0] st, output logic [31:0] rd, output logic er);
    int n;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= {2'b00, idx, 2'b00};
    i_pwdata <= wd;
    i_pstrb <= st;
    @(posedge i_clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    rd = o_prdata;
    er = o_pslverr;
    if (n >= 50) n_errors++;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, 4'hf, rdv, err);
  endtask : wr
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0, 4'h0, rdv, err);
    chk(rdv, exp);
  endtask : rdc
  task automatic setcfg(input int ph, input logic [7:0] c, input logic [7:0] r);
    cfg[ph] = c;
    refv[ph] = r;
    wr(8'(wuac_pkg::IDX_AMP_CFG + 4 * ph), 32'(c));
    wr(8'(wuac_pkg::IDX_AMP_REF + 4 * ph), 32'(r));
    rdc(8'(wuac_pkg::IDX_AMP_CFG + 4 * ph), 32'(c));
  endtask : setcfg
  task automatic setmask(input logic [3:0] m);
    mask_v = m;
    wr(wuac_pkg::IDX_IRQ_MASK, 32'(m));
  endtask : setmask
  task automatic meas(input int ph, input logic [7:0] d);
    int          r;
    int          n;
    logic        w;
    logic [31:0] sb;
    r = cfg[ph][0] ? int'(avg[ph]) : int'(refv[ph]);
    w = ((int'(d) > r) ? int'(d) - r : r - int'(d)) > int'(cfg[ph][7:4]);
    if (!w || cfg[ph][3]) begin
      avg[ph] = 8'(int'(avg[ph]) + ((int'(d) - int'(avg[ph])) >>> (2 + cfg[ph][2:1])));
    end
    sb = ph ? 32'h2 : 32'h1;
    wr(wuac_pkg::IDX_WAKE_CTRL, ph ? 32'h2 : 32'h4);
    @(posedge i_clk);
    i_wake_timeout <= 1'b1;
    @(posedge i_clk);
    i_wake_timeout <= 1'b0;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while ((ph ? o_phase_meas_req : o_amp_meas_req) !== 1'b1 && n < 9);
    chk(32'(n), 32'h1);
    @(posedge i_clk);
    if (ph == 1) i_phase_meas <= {1'b1, d};
    else i_amp_meas <= {1'b1, d};
    @(posedge i_clk);
    i_phase_meas <= 9'h000;
    i_amp_meas <= 9'h000;
    repeat (3) @(negedge i_clk);
    chk(32'(o_irq), 32'(w && (mask_v & sb) != 0));
    rdc(8'(wuac_pkg::IDX_AMP_RES + 4 * ph), 32'(d));
    rdc(8'(wuac_pkg::IDX_AMP_AVG + 4 * ph), 32'(avg[ph]));
    rdc(wuac_pkg::IDX_IRQ_STAT, w ? sb : 32'h0);
    wr(wuac_pkg::IDX_IRQ_STAT, 32'hf);
  endtask : meas
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_regs;
    for (int i = 0; i < 11; i++) begin
      rdc((i < 8) ? 8'(8'h33 + i) : 8'(8'h38 + i), 32'h0);
    end
    apb(1'b0, 8'h3b, 32'h0, 4'h0, rdv, err);
    chk(rdv, 32'h0);
    chk(32'(err), 32'h1);
    wr(wuac_pkg::IDX_AMP_AVG, 32'hff);
    rdc(wuac_pkg::IDX_AMP_AVG, 32'h0);
    wr(wuac_pkg::IDX_AMP_REF, 32'ha5);
    wr(wuac_pkg::IDX_PH_REF, 32'h5a);
    apb(1'b1, wuac_pkg::IDX_PH_REF, 32'h11, 4'he, rdv, err);
    rdc(wuac_pkg::IDX_AMP_REF, 32'ha5);
    rdc(wuac_pkg::IDX_PH_REF, 32'h5a);
    $display("test regs done");
  endtask : t_regs
  task automatic t_amp;
    setmask(4'hf);
    setcfg(0, 8'h30, 8'h50);
    meas(0, 8'h53);
    meas(0, 8'h54);
    setmask(4'he);
    meas(0, 8'h54);
    setmask(4'hf);
    setcfg(0, 8'h38, 8'h50);
    meas(0, 8'h60);
    setcfg(0, 8'h39, 8'h50);
    meas(0, 8'h29);
    meas(0, 8'h20);
    wr(wuac_pkg::IDX_WAKE_CTRL, 32'h6);
    @(posedge i_clk);
    i_wake_timeout <= 1'b1;
    @(posedge i_clk);
    i_wake_timeout <= 1'b0;
    repeat (260) @(posedge i_clk);
    rdc(wuac_pkg::IDX_IRQ_STAT, 32'hc);
    wr(wuac_pkg::IDX_IRQ_STAT, 32'hf);
    rdc(wuac_pkg::IDX_IRQ_STAT, 32'h0);
    $display("test amplitude done");
  endtask : t_amp
  task automatic t_phase;
    for (int k = 0; k < 4; k++) begin
      setcfg(1, 8'(8'hf8 | (k << 1)), 8'h00);
      meas(1, 8'hff);
    end
    setcfg(1, 8'hf0, 8'h00);
    meas(1, 8'hff);
    setcfg(1, 8'h21, 8'h00);
    meas(1, 8'(avg[1] + 8'h02));
    meas(1, 8'h10);
    $display("test phase done");
  endtask : t_phase
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    avg[0] = 8'h00;
    avg[1] = 8'h00;
    repeat (16) @(posedge i_clk);
    i_reset_n <= 1'b1;
    t_regs();
    t_amp();
    t_phase();
    finish_test();
  end
  initial begin
    #300000;
    n_errors++;
    finish_test();
  end
endmodule : wuac_top_tb
`default_nettype wire
